// ===== design/e1_alarm_params.svh
// Constants of the E1 alarm monitor.
// Assumes inclusion by bare name from the design module.
`ifndef E1_ALARM_PARAMS_SVH
`define E1_ALARM_PARAMS_SVH

// Register indexes; byte address = 4 * index
`define IDX_RESYNC_EVENT_FLAGS      8'h12
`define IDX_SYNC_SEARCH_LIVE_STATUS 8'h30
`define IDX_RX_CONTROL_ONE          8'h33
`define IDX_RX_CONTROL_TWO          8'h34
`define IDX_TX_CONTROL_TWO          8'h36
`define IDX_ALARM_STATUS            8'h3F

// Reset values
`define RST_CTRL                    8'h00
`define RST_EVENTS                  3'h0
`define RST_SYNC_COUNT              6'h00

// resync_event_flags fields
`define POS_CAS_RESYNC              0
`define POS_FAS_RESYNC              1
`define POS_CRC_RESYNC              2
// sync_search_live_status fields
`define POS_CRC_SEARCH              0
`define POS_CAS_SEARCH              1
`define POS_FAS_SEARCH              2
// Control fields
`define POS_MANUAL_RESYNC           0
`define POS_RX_CRC_ENABLE           3
`define POS_CL_ALT                  0
`define POS_AUTO_RAI                0
`define POS_AUTO_AIS                1

// Line criteria counts
`define CL_ZEROS_SHORT              12'd255
`define CL_ZEROS_LONG               12'd2048
`define CL_ONES_MIN                 8'd32
`define CL_WINDOW_BITS              8'd255
`define AIS_WINDOW_BITS             10'd512
`define AIS_ZEROS_MAX               10'd2
`define FAS_ERR_RUN                 2'd3
`define CAS_ERR_RUN                 2'd2
`define RA_RUN                      2'd3
`define DMA_RUN                     2'd2
`define CRC_BLOCK_WINDOW            10'd1000
`define CRC_BLOCK_ERR_MIN           10'd915

// CRC4 MF sync timing
`define CRC_LATE_MS                 128
`define CRC_ABANDON_MS              400
`define CLK_KHZ                     200000

`endif

// ===== design/e1_alarm_pkg.sv
// Types shared by the E1 alarm monitor.
// Assumes the params header is on the include path.
package e1_alarm_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
endpackage

// ===== design/e1_alarm_monitor_autogen.sv
// E1 receive alarms, resync events and automatic AIS/RAI request.
// Assumes a frame synchronizer beside it giving bit and frame strobes,
// all synchronous to clock, and software on an AXI4-Lite master.
//
// Overview of operation
// [RULE1] Auto AIS on: force transmit AIS while sync lost, all-ones or carrier lost.
// [RULE2] Auto RAI on: send RAI on those, or CRC4 MF missing 128ms after FAS.
// [RULE3] Auto RAI on: constant RAI when CRC4 MF sync not found within 400ms.
// [RULE4] Host must never enable auto AIS and auto RAI together.
// [RULE5] CAS resync event, bit 0, on two consecutive bad CAS MF words.
// [RULE6] FAS resync event, bit 1, on three consecutive bad FAS words.
// [RULE7] CRC resync event, bit 2, on 915 of 1000 CRC4 codewords bad.
// [RULE8] Live bit 0 reads 1 while hunting CRC4 multiframe alignment.
// [RULE9] Live bit 1 reads 1 while hunting CAS multiframe alignment.
// [RULE10] Live bit 2 reads 1 while hunting FAS alignment.
// [RULE11] Sync counter counts 8ms CRC4 timeouts; clears on CRC4 sync or CRC4 off.
// [RULE12] Six-bit wrapping counter; bits 3..7 show counter bits 0,2,3,4,5.
// [RULE13] Search bits and counter are live read-only values, no write needed.
// [RULE14] Sync lost from power-up, on any resync criterion, and on manual resync.
// [RULE15] Carrier lost after 255/2048 zeros; cleared by 32 ones in 255 bits.
// [RULE16] Remote alarm set on three NAS bit3 ones, cleared on three zeros.
// [RULE17] All-ones set on fewer than three zeros in 512 bits, else cleared.
// [RULE18] Distant MF alarm when TS16 frame 0 bit 6 is 1 two multiframes running.
// [RULE19] Link id detected when two of three last Sa7 bits are zero.
// [RULE20] Alternate criteria bit: 0 selects 255 zeros, 1 selects 2048 zeros.
// [RULE21] CRC4 enable bit turns CRC4 on; clearing it clears the sync counter.
// [RULE22] Resync event bits stay latched until software reads the event register.
// [RULE23] Sync lost clears once alignment is regained at all enabled levels.
`timescale 1ns/1ps
`include "e1_alarm_params.svh"

module e1_alarm_monitor_autogen
    import e1_alarm_pkg::*;
#(
    parameter int unsigned CRC_LATE_CYCLES    = `CRC_LATE_MS * `CLK_KHZ,
    parameter int unsigned CRC_ABANDON_CYCLES = `CRC_ABANDON_MS * `CLK_KHZ
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // AXI4-Lite slave
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Receive line and synchronizer side
    input  wire logic        rx_bit_en,
    input  wire logic        rx_bit,
    input  wire logic        fas_word_en,
    input  wire logic        fas_word_err,
    input  wire logic        cas_mf_word_en,
    input  wire logic        cas_mf_word_err,
    input  wire logic        crc_block_en,
    input  wire logic        crc_block_err,
    input  wire logic        nas_bit3_en,
    input  wire logic        nas_bit3,
    input  wire logic        mf_ts16_bit6_en,
    input  wire logic        mf_ts16_bit6,
    input  wire logic        sa7_en,
    input  wire logic        sa7,
    input  wire logic        crc_search_timeout,
    input  wire logic        crc_mf_hunting,
    input  wire logic        cas_mf_hunting,
    input  wire logic        fas_hunting,
    input  wire logic        sync_all_levels,
    // Toward the synchronizer and transmitter
    output logic             manual_resync_pulse,
    output logic             rx_sync_lost,
    output logic             tx_force_ais,
    output logic             tx_force_rai
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [1:0] run_count(input logic [1:0] cnt, input logic hit,
                                             input logic [1:0] top);
        if (!hit)
            run_count = 2'd0;
        else if (cnt >= top)
            run_count = top;
        else
            run_count = cnt + 2'd1;
    endfunction

    function automatic logic is_reg(input logic [9:0] addr, input logic [7:0] idx);
        is_reg = (addr[9:2] == idx);
    endfunction

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [7:0]  rx_control_one_r;
    logic [7:0]  rx_control_two_r;
    logic [7:0]  tx_control_two_r;
    logic [9:0]  aw_addr_r;
    logic        aw_held_r;
    logic [31:0] w_data_r;
    logic        w_strb0_r;
    logic        w_held_r;
    logic        do_write;
    logic        aw_hit;
    logic        event_read;
    logic [2:0]  events_r;
    logic [5:0]  sync_count_r;
    logic [2:0]  hunting_r;
    logic        rx_carrier_lost, rx_remote_alarm, rx_unframed_allones;
    logic        rx_distant_mf_alarm, link_id_detected;
    logic [31:0] rd_nxt;
    logic        rd_ok;

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign aw_hit   = is_reg(aw_addr_r, `IDX_RX_CONTROL_ONE)
                   || is_reg(aw_addr_r, `IDX_RX_CONTROL_TWO)
                   || is_reg(aw_addr_r, `IDX_TX_CONTROL_TWO);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 10'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held_r     <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            w_held_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb0_r    <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb0_r    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held_r     <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Manual resync is a write-one strobe; it reads as zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_control_one_r    <= `RST_CTRL;
            rx_control_two_r    <= `RST_CTRL;
            tx_control_two_r    <= `RST_CTRL;
            manual_resync_pulse <= 1'b0;
        end else begin
            manual_resync_pulse <= 1'b0;
            if (do_write && w_strb0_r) begin
                if (is_reg(aw_addr_r, `IDX_RX_CONTROL_ONE)) begin
                    rx_control_one_r <= w_data_r[7:0] & ~(8'h01 << `POS_MANUAL_RESYNC);
                    manual_resync_pulse <= w_data_r[`POS_MANUAL_RESYNC]; // RULE14
                end else if (is_reg(aw_addr_r, `IDX_RX_CONTROL_TWO)) begin
                    rx_control_two_r <= w_data_r[7:0];
                end else if (is_reg(aw_addr_r, `IDX_TX_CONTROL_TWO)) begin
                    tx_control_two_r <= w_data_r[7:0];
                end
            end
        end
    end

    // Live read data; the counter hides its bit 1
    always_comb begin
        rd_nxt = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (is_reg(s_axi_araddr, `IDX_RESYNC_EVENT_FLAGS)) begin
            rd_nxt[2:0] = events_r;
        end else if (is_reg(s_axi_araddr, `IDX_SYNC_SEARCH_LIVE_STATUS)) begin
            rd_nxt[7:0] = {sync_count_r[5:2], sync_count_r[0], hunting_r}; // RULE12 RULE13
        end else if (is_reg(s_axi_araddr, `IDX_RX_CONTROL_ONE)) begin
            rd_nxt[7:0] = rx_control_one_r;
        end else if (is_reg(s_axi_araddr, `IDX_RX_CONTROL_TWO)) begin
            rd_nxt[7:0] = rx_control_two_r;
        end else if (is_reg(s_axi_araddr, `IDX_TX_CONTROL_TWO)) begin
            rd_nxt[7:0] = tx_control_two_r;
        end else if (is_reg(s_axi_araddr, `IDX_ALARM_STATUS)) begin
            rd_nxt[7:0] = {tx_force_rai, tx_force_ais, link_id_detected,
                           rx_distant_mf_alarm, rx_unframed_allones, rx_remote_alarm,
                           rx_carrier_lost, rx_sync_lost};
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign event_read = s_axi_arvalid && s_axi_arready
                     && is_reg(s_axi_araddr, `IDX_RESYNC_EVENT_FLAGS);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid  <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // Resync criteria events
    // ************************************************************
    logic [1:0] fas_run_r, cas_run_r;
    logic [9:0] crc_blocks_r, crc_errs_r;
    logic [2:0] ev_set;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fas_run_r <= 2'd0;
            cas_run_r <= 2'd0;
        end else begin
            if (fas_word_en)
                fas_run_r <= run_count(fas_run_r, fas_word_err, `FAS_ERR_RUN);
            if (cas_mf_word_en)
                cas_run_r <= run_count(cas_run_r, cas_mf_word_err, `CAS_ERR_RUN);
        end
    end

    // Fixed blocks of 1000 codewords rather than a sliding window
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            crc_blocks_r <= 10'd0;
            crc_errs_r   <= 10'd0;
        end else if (crc_block_en) begin
            if (crc_blocks_r == `CRC_BLOCK_WINDOW - 10'd1) begin
                crc_blocks_r <= 10'd0;
                crc_errs_r   <= 10'd0;
            end else begin
                crc_blocks_r <= crc_blocks_r + 10'd1;
                crc_errs_r   <= crc_errs_r + {9'd0, crc_block_err};
            end
        end
    end

    always_comb begin
        ev_set = 3'b000;
        ev_set[`POS_CAS_RESYNC] = cas_mf_word_en && cas_mf_word_err
                               && (cas_run_r == `CAS_ERR_RUN - 2'd1); // RULE5
        ev_set[`POS_FAS_RESYNC] = fas_word_en && fas_word_err
                               && (fas_run_r == `FAS_ERR_RUN - 2'd1); // RULE6
        ev_set[`POS_CRC_RESYNC] = crc_block_en
                               && (crc_blocks_r == `CRC_BLOCK_WINDOW - 10'd1)
                               && (crc_errs_r + {9'd0, crc_block_err}
                                   >= `CRC_BLOCK_ERR_MIN); // RULE7
    end

    // A new event in the read cycle survives the clear
    always_ff @(posedge clock) begin
        if (!rst_b)
            events_r <= `RST_EVENTS;
        else
            events_r <= (event_read ? 3'b000 : events_r) | ev_set; // RULE22
    end

    // ************************************************************
    // Loss of sync and live synchronizer status
    // ************************************************************
    always_ff @(posedge clock) begin
        if (!rst_b)
            rx_sync_lost <= 1'b1; // RULE14
        else if (|ev_set || manual_resync_pulse)
            rx_sync_lost <= 1'b1; // RULE14
        else if (sync_all_levels)
            rx_sync_lost <= 1'b0; // RULE23
    end

    always_ff @(posedge clock) begin
        if (!rst_b)
            hunting_r <= 3'b000;
        else begin
            hunting_r[`POS_CRC_SEARCH] <= crc_mf_hunting; // RULE8
            hunting_r[`POS_CAS_SEARCH] <= cas_mf_hunting; // RULE9
            hunting_r[`POS_FAS_SEARCH] <= fas_hunting; // RULE10
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b)
            sync_count_r <= `RST_SYNC_COUNT;
        else if (!rx_control_one_r[`POS_RX_CRC_ENABLE] || !crc_mf_hunting)
            sync_count_r <= `RST_SYNC_COUNT; // RULE11 RULE21
        else if (crc_search_timeout)
            sync_count_r <= sync_count_r + 6'd1; // RULE11 RULE12
    end

    // ************************************************************
    // Line alarms
    // ************************************************************
    logic [11:0] zero_run_r;
    logic [11:0] zero_limit;
    logic [7:0]  cl_pos_r, cl_ones_r;
    logic [9:0]  ais_pos_r, ais_zeros_r;
    logic [1:0]  ra_one_r, ra_zero_r, dma_run_r;
    logic [2:0]  sa7_hist_r;

    assign zero_limit = rx_control_two_r[`POS_CL_ALT] ? `CL_ZEROS_LONG
                                                      : `CL_ZEROS_SHORT; // RULE20

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            zero_run_r      <= 12'd0;
            cl_pos_r        <= 8'd0;
            cl_ones_r       <= 8'd0;
            rx_carrier_lost <= 1'b0;
        end else if (rx_bit_en) begin
            zero_run_r <= rx_bit ? 12'd0
                        : (zero_run_r == zero_limit ? zero_run_r : zero_run_r + 12'd1);
            if (!rx_bit && zero_run_r == zero_limit - 12'd1)
                rx_carrier_lost <= 1'b1; // RULE15
            else if (cl_pos_r == `CL_WINDOW_BITS - 8'd1
                     && cl_ones_r + {7'd0, rx_bit} >= `CL_ONES_MIN)
                rx_carrier_lost <= 1'b0; // RULE15
            if (cl_pos_r == `CL_WINDOW_BITS - 8'd1) begin
                cl_pos_r  <= 8'd0;
                cl_ones_r <= 8'd0;
            end else begin
                cl_pos_r  <= cl_pos_r + 8'd1;
                cl_ones_r <= cl_ones_r + {7'd0, rx_bit};
            end
        end
    end

    // Two-frame windows are counted on bit strobes, not aligned to frames
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ais_pos_r           <= 10'd0;
            ais_zeros_r         <= 10'd0;
            rx_unframed_allones <= 1'b0;
        end else if (rx_bit_en) begin
            if (ais_pos_r == `AIS_WINDOW_BITS - 10'd1) begin
                rx_unframed_allones <= (ais_zeros_r + {9'd0, !rx_bit})
                                       <= `AIS_ZEROS_MAX; // RULE17
                ais_pos_r   <= 10'd0;
                ais_zeros_r <= 10'd0;
            end else begin
                ais_pos_r   <= ais_pos_r + 10'd1;
                ais_zeros_r <= ais_zeros_r + {9'd0, !rx_bit};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ra_one_r        <= 2'd0;
            ra_zero_r       <= 2'd0;
            rx_remote_alarm <= 1'b0;
        end else if (nas_bit3_en) begin
            ra_one_r  <= run_count(ra_one_r, nas_bit3, `RA_RUN);
            ra_zero_r <= run_count(ra_zero_r, !nas_bit3, `RA_RUN);
            if (nas_bit3 && ra_one_r == `RA_RUN - 2'd1)
                rx_remote_alarm <= 1'b1; // RULE16
            else if (!nas_bit3 && ra_zero_r == `RA_RUN - 2'd1)
                rx_remote_alarm <= 1'b0; // RULE16
        end
    end

    // The distant alarm drops on the first multiframe with the bit clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dma_run_r           <= 2'd0;
            rx_distant_mf_alarm <= 1'b0;
        end else if (mf_ts16_bit6_en) begin
            dma_run_r           <= run_count(dma_run_r, mf_ts16_bit6, `DMA_RUN);
            rx_distant_mf_alarm <= mf_ts16_bit6
                                && (dma_run_r >= `DMA_RUN - 2'd1); // RULE18
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sa7_hist_r       <= 3'b111;
            link_id_detected <= 1'b0;
        end else if (sa7_en) begin
            sa7_hist_r       <= {sa7_hist_r[1:0], sa7};
            link_id_detected <= ({1'b0, !sa7_hist_r[1]} + {1'b0, !sa7_hist_r[0]}
                                 + {1'b0, !sa7}) >= 2'd2; // RULE19
        end
    end

    // ************************************************************
    // Automatic transmit alarms
    // ************************************************************
    logic [31:0] crc_wait_r;
    logic        crc_wait_on;

    // Time since FAS sync with CRC4 MF missing
    assign crc_wait_on = rx_control_one_r[`POS_RX_CRC_ENABLE] && !fas_hunting
                      && crc_mf_hunting;

    always_ff @(posedge clock) begin
        if (!rst_b)
            crc_wait_r <= 32'd0;
        else if (!crc_wait_on)
            crc_wait_r <= 32'd0;
        else if (crc_wait_r != CRC_ABANDON_CYCLES)
            crc_wait_r <= crc_wait_r + 32'd1;
    end

    // Both enables at once is a host fault; each output follows its own enable
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_force_ais <= 1'b0;
            tx_force_rai <= 1'b0;
        end else begin
            tx_force_ais <= tx_control_two_r[`POS_AUTO_AIS]
                         && (rx_sync_lost || rx_unframed_allones
                             || rx_carrier_lost); // RULE1 RULE4
            tx_force_rai <= tx_control_two_r[`POS_AUTO_RAI]
                         && (rx_sync_lost || rx_unframed_allones || rx_carrier_lost
                             || crc_wait_r >= CRC_LATE_CYCLES // RULE2
                             || crc_wait_r >= CRC_ABANDON_CYCLES); // RULE3
        end
    end

endmodule

// ===== verif/e1_alarm_properties.sv
// Port checks of the E1 alarm monitor, bound into the design.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module e1_alarm_properties
    import e1_alarm_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        manual_resync_pulse,
    input wire logic        rx_sync_lost,
    input wire logic        sync_all_levels
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_reset_sync_lost: assert property (!$past(rst_b) |-> rx_sync_lost)
        else $error("sync lost not set after reset");
    a_manual_sets_loss: assert property (manual_resync_pulse |=> rx_sync_lost)
        else $error("manual resync did not set sync lost");
    a_manual_pulse_single: assert property (manual_resync_pulse |=> !manual_resync_pulse)
        else $error("manual resync pulse longer than one cycle");
    a_loss_held_unaligned: assert property (rx_sync_lost && !sync_all_levels |=> rx_sync_lost)
        else $error("sync lost cleared without alignment");
    a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_unmapped_read_err: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 10'h004 |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    c_manual: cover property (manual_resync_pulse);
    c_regained: cover property ($fell(rx_sync_lost));
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind e1_alarm_monitor_autogen e1_alarm_properties i_e1_alarm_properties (.*);

// ===== verif/e1_line_model.sv
// Receive E1 line: a bit every cycle, a frame strobe every 16.
// Assumes the bench fans the strobes out to per-field strobes.
`timescale 1ns/1ps
module e1_line_model (
    input  wire logic clock,
    input  wire logic zeros,
    output logic      bit_en = 1'b0,
    output logic      frame_en = 1'b0,
    output logic      data = 1'b1
);
    logic [3:0] slot_r = 4'h0;

    // Short frames make multiframe alarms quick
    always_ff @(posedge clock) begin
        slot_r   <= slot_r + 4'h1;
        bit_en   <= 1'b1;
        frame_en <= (slot_r == 4'hF);
        data     <= ~zeros;
    end
endmodule

// ===== verif/tb.sv
// Self-checking bench of the E1 alarm monitor.
// Assumes package, line model and checker compiled first.
`timescale 1ns/1ps
module tb import e1_alarm_pkg::*; ;
    logic        clock = 1'b0, rst_b = 1'b0, zeros = 1'b0, ra = 1'b0, bad = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, bit_en, frame_en, rx_bit, crc_search_timeout = 1'b0;
    logic crc_mf_hunting = 1'b0, cas_mf_hunting = 1'b0, fas_hunting = 1'b0, sync_all_levels = 1'b0;
    logic manual_resync_pulse, rx_sync_lost, tx_force_ais, tx_force_rai;
    logic [33:0] exp_q[$];
    int fail_count = 0, checked = 0, n, h;
    wire rx_bit_en = bit_en, crc_block_en = bit_en, fas_word_en = frame_en;
    wire cas_mf_word_en = frame_en, nas_bit3_en = frame_en, mf_ts16_bit6_en = frame_en;
    wire sa7_en = frame_en, fas_word_err = bad, cas_mf_word_err = bad, crc_block_err = bad;
    wire nas_bit3 = ra, mf_ts16_bit6 = ra, sa7 = ~ra;

    e1_line_model i_e1_line_model (.clock(clock), .zeros(zeros), .bit_en(bit_en),
        .frame_en(frame_en), .data(rx_bit));
    // Shortened CRC timers keep the run brief
    e1_alarm_monitor_autogen #(.CRC_LATE_CYCLES(50), .CRC_ABANDON_CYCLES(150))
        i_e1_alarm_monitor_autogen (.*);

    always #2.5 clock = ~clock;

    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic end_of_test(input bit hung);
        fail_count += hung;
        $display("checked %0d, failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        int k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 99);
        s_axi_bready <= 1'b0;
        if (k == 99) end_of_test(1'b1);
    endtask

    task automatic rd(input logic [9:0] a, input logic [1:0] r, input logic [7:0] d);
        int k = 0;
        exp_q.push_back({r, 24'h000000, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 99);
        s_axi_rready <= 1'b0;
        if (k == 99) end_of_test(1'b1);
    endtask

    task automatic cmp(input logic [33:0] e);
        checked++;
        if (s_axi_rresp !== e[33:32] || (e[33:32] == RESP_OKAY && s_axi_rdata !== e[31:0])) begin
            fail_count++;
            $display("Error at %0t: read %h/%h, want %h", $time, s_axi_rresp, s_axi_rdata, e);
        end
    endtask

    always @(posedge clock) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) cmp(exp_q.pop_front());
    end

    initial begin
        void'($urandom(39));
        cyc(2);
        rst_b <= 1'b1;
        cyc(2);
        rd(10'h048, RESP_OKAY, 8'h00);
        rd(10'h0C0, RESP_OKAY, 8'h00);
        rd(10'h004, RESP_SLVERR, 8'h00);
        cyc(1100);
        rd(10'h0FC, RESP_OKAY, 8'h09);
        wr(10'h0D8, 8'h02);
        cyc(3);
        rd(10'h0FC, RESP_OKAY, 8'h49);
        zeros <= 1'b1;
        cyc(1100);
        rd(10'h0FC, RESP_OKAY, 8'h43);
        wr(10'h0D8, 8'h01);
        cyc(3);
        rd(10'h0FC, RESP_OKAY, 8'h83);
        zeros <= 1'b0;
        ra <= 1'b1;
        sync_all_levels <= 1'b1;
        cyc(1100);
        rd(10'h0FC, RESP_OKAY, 8'hBC);
        wr(10'h0D8, 8'h00);
        cyc(3);
        rd(10'h0FC, RESP_OKAY, 8'h3C);
        $display("alarm tests done");
        bad <= 1'b1;
        cyc(2000);
        bad <= 1'b0;
        cyc(2);
        rd(10'h048, RESP_OKAY, 8'h07);
        rd(10'h048, RESP_OKAY, 8'h00);
        $display("event tests done");
        h = $urandom % 8;
        n = 62 + $urandom % 6;
        crc_mf_hunting <= 1'b1;
        cas_mf_hunting <= h[1];
        fas_hunting <= h[2];
        wr(10'h0CC, 8'h09);
        repeat (n) begin
            crc_search_timeout <= 1'b1;
            cyc(1);
            crc_search_timeout <= 1'b0;
            cyc(1);
        end
        cyc(2);
        rd(10'h0C0, RESP_OKAY, {n[5:2], n[0], h[2:1], 1'b1});
        wr(10'h0CC, 8'h00);
        cyc(2);
        rd(10'h0C0, RESP_OKAY, {5'h00, h[2:1], 1'b1});
        $display("live status tests done");
        cyc(4);
        end_of_test(1'b0);
    end
endmodule
